// ### design/crj_cond_eval.sv
// Shared constants and the condition code evaluator
`timescale 1ns/1ps
package crj_pkg;
   // Wishbone register byte offsets
   localparam logic [9:0] OFF_CTRL = 10'h000;
   localparam logic [9:0] OFF_INSTR = 10'h004;
   localparam logic [9:0] OFF_PC = 10'h008;
   localparam logic [9:0] OFF_IP = 10'h00c;
   localparam logic [9:0] OFF_SP = 10'h010;
   localparam logic [9:0] OFF_FLAGS = 10'h014;
   localparam logic [9:0] OFF_SYSMODE = 10'h018;
   localparam logic [9:0] OFF_SHADOW = 10'h01c;
   localparam logic [9:0] OFF_WRP = 10'h020;
   localparam logic [9:0] OFF_STATUS = 10'h024;
   localparam logic [1:0] WIN_REGFILE = 2'h1;
   // Control and status bit positions
   localparam int CTRL_GO = 0;
   localparam int CTRL_FIRQ = 1;
   localparam int CTRL_SLOW = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_TAKEN = 1;
   localparam int STAT_ILLEGAL = 2;
   // Flag bit positions
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;
   localparam int FL_FIS = 1;
   localparam int SYM_GIE = 0;
   localparam logic [7:0] FLAGS_ADDR = 8'hd5;
   // Opcodes and low-nibble opcodes
   localparam logic [7:0] OP_INTERRUPT_RETURN_INSTR = 8'hbf;
   localparam logic [7:0] OP_JP_IND = 8'h30;
   localparam logic [7:0] OP_LDB = 8'h47;
   localparam logic [7:0] OP_LD_R_IR = 8'hc7;
   localparam logic [7:0] OP_LD_IR_R = 8'hd7;
   localparam logic [7:0] OP_LD_RR = 8'he4;
   localparam logic [7:0] OP_LD_R_IND = 8'he5;
   localparam logic [7:0] OP_LD_R_IM = 8'he6;
   localparam logic [7:0] OP_LD_IND_IM = 8'hd6;
   localparam logic [7:0] OP_LD_IND_R = 8'hf5;
   localparam logic [3:0] LO_JP = 4'hd;
   localparam logic [3:0] LO_JR = 4'hb;
   localparam logic [3:0] LO_LD_IM = 4'hc;
   localparam logic [3:0] LO_LD_FROM = 4'h8;
   localparam logic [3:0] LO_LD_TO = 4'h9;
   // Cycle counts
   localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_NORM = 4'd10;
   localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_SLOW = 4'd12;
   localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_FAST = 4'd6;
   localparam logic [3:0] CYC_JP = 4'd8;
   localparam logic [3:0] CYC_JR = 4'd6;
   localparam logic [3:0] CYC_SHORT = 4'd4;
   localparam logic [3:0] CYC_LONG = 4'd6;
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

module crj_cond_eval
(
   input wire logic [3:0] condCode,
   input wire logic [7:0] flags,
   output logic condTrue
);
   logic c;
   logic z;
   logic s;
   logic v;
   assign c = flags[crj_pkg::FL_C];
   assign z = flags[crj_pkg::FL_Z];
   assign s = flags[crj_pkg::FL_S];
   assign v = flags[crj_pkg::FL_V];
   // ----------------------------------------
   // Sixteen-entry condition table
   // ----------------------------------------
   // condition table lookup
   always_comb
   begin
      case (condCode)
         4'h0: condTrue = 1'b0;
         4'h1: condTrue = s ^ v;
         4'h2: condTrue = z | (s ^ v);
         4'h3: condTrue = c | z;
         4'h4: condTrue = v;
         4'h5: condTrue = s;
         4'h6: condTrue = z;
         4'h7: condTrue = c;
         4'h8: condTrue = 1'b1;
         4'h9: condTrue = ~(s ^ v);
         4'ha: condTrue = ~(z | (s ^ v));
         4'hb: condTrue = ~c & ~z;
         4'hc: condTrue = ~v;
         4'hd: condTrue = ~s;
         4'he: condTrue = ~z;
         default: condTrue = ~c;
      endcase
   end
endmodule

// ### design/crj_exec_unit.sv
// Execution unit for return, jump and load instructions
`timescale 1ns/1ps
// How it works
// - Normal return pops flags then PC, SP up by three, sets GIE; 10/12 cycles.
// - Normal return only while fast status flag in flags bit one is clear.
// - Fast return swaps PC/IP, restores shadow flags, clears fast flag, sets GIE; 6 cycles.
// - Fast interrupt entry swaps PC and IP; IP keeps the return address.
// - Conditional absolute jump: cc|D, 16-bit target, 8 cycles, loads PC when true.
// - Opcode 30 loads PC from the register pair named by its operand.
// - Relative jump adds signed displacement to address after the instruction when true.
// - Relative jump is two bytes, cc|B, 6 cycles.
// - Jumps, byte loads and bit loads leave all flags unchanged unless a load writes FLAGS_ADDR.
// - Byte load copies source to destination; short forms rC r8 r9 take 4 cycles.
// - Bit load 47, three bytes, 6 cycles, moves one bit to/from working bit zero.
// - Bit load byte two: register nibble, three bit index bits, direction in LSB.
// - System mode bit zero enables interrupts; entry accepted only while it is one.
module crj_exec_unit
#(
   parameter int REG_DEPTH = 32
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic busy,
   output logic globalIrqEnable,
   output logic fetchNext
);
   localparam int IDXW = $clog2(REG_DEPTH);

   logic [15:0] pc_r, pc_nxt, ip_r, ip_nxt;
   logic [7:0] sp_r, sp_nxt, flags_r, flags_nxt, sym_r, sym_nxt;
   logic [7:0] shadow_r, shadow_nxt, wrp_r, wrp_nxt;
   logic [23:0] instr_r, instr_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic busy_r, busy_nxt, slow_r, slow_nxt, taken_r, taken_nxt;
   logic illegal_r, illegal_nxt, ack_r, ack_nxt, fetch_r, fetch_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [7:0] mem_r [REG_DEPTH];
   logic memWe;
   logic [IDXW-1:0] memIdx;
   logic [7:0] memData;
   logic condTrue;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] rdReg(input logic [7:0] a);
      if (a == crj_pkg::FLAGS_ADDR)
         rdReg = flags_r;
      else
         rdReg = mem_r[a[IDXW-1:0]];
   endfunction

   function automatic logic [7:0] workAddr(input logic [3:0] n);
      workAddr = wrp_r + {4'h0, n};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
   endfunction

   function automatic logic [3:0] cycFor(input logic [7:0] op, input logic fast_irq_status_flag, input logic slow);
      if (op == crj_pkg::OP_INTERRUPT_RETURN_INSTR)
         cycFor = fast_irq_status_flag ? crj_pkg::CYC_INTERRUPT_RETURN_INSTR_FAST : (slow ? crj_pkg::CYC_INTERRUPT_RETURN_INSTR_SLOW : crj_pkg::CYC_INTERRUPT_RETURN_INSTR_NORM);
      else if (op == crj_pkg::OP_JP_IND || op[3:0] == crj_pkg::LO_JP)
         cycFor = crj_pkg::CYC_JP;
      else if (op[3:0] == crj_pkg::LO_JR)
         cycFor = crj_pkg::CYC_JR;
      else if (op == crj_pkg::OP_LDB || op == crj_pkg::OP_LD_RR || op == crj_pkg::OP_LD_R_IND
               || op == crj_pkg::OP_LD_R_IM || op == crj_pkg::OP_LD_IND_IM || op == crj_pkg::OP_LD_IND_R)
         cycFor = crj_pkg::CYC_LONG;
      else
         cycFor = crj_pkg::CYC_SHORT;
   endfunction

   crj_cond_eval u_cond
   (
      .condCode(instr_r[7:4]),
      .flags(flags_r),
      .condTrue(condTrue)
   );

   // ----------------------------------------
   // Bus, sequencing and execution
   // ----------------------------------------
   always_comb
   begin
      logic [7:0] op, b1, b2, wrAddr, wrData, src, old;
      logic wrEn, commit, go, retire;
      logic [31:0] rd, w;
      op = instr_r[7:0];
      b1 = instr_r[15:8];
      b2 = instr_r[23:16];
      wrAddr = 8'h00;
      wrData = 8'h00;
      src = 8'h00;
      old = 8'h00;
      wrEn = 1'b0;
      rd = 32'h0000_0000;
      w = 32'h0000_0000;
      pc_nxt = pc_r;
      ip_nxt = ip_r;
      sp_nxt = sp_r;
      flags_nxt = flags_r;
      sym_nxt = sym_r;
      shadow_nxt = shadow_r;
      wrp_nxt = wrp_r;
      instr_nxt = instr_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      slow_nxt = slow_r;
      taken_nxt = taken_r;
      illegal_nxt = illegal_r;
      fetch_nxt = 1'b0;
      memWe = 1'b0;
      memIdx = '0;
      memData = 8'h00;
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      commit = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
      go = 1'b0;
      retire = busy_r & (cnt_r == 4'h0);

      // Read mux, loaded into the data register with the ack
      if (wb_adr_i == crj_pkg::OFF_CTRL)
         rd[crj_pkg::CTRL_SLOW] = slow_r;
      else if (wb_adr_i == crj_pkg::OFF_INSTR)
         rd = {8'h00, instr_r};
      else if (wb_adr_i == crj_pkg::OFF_PC)
         rd = {16'h0000, pc_r};
      else if (wb_adr_i == crj_pkg::OFF_IP)
         rd = {16'h0000, ip_r};
      else if (wb_adr_i == crj_pkg::OFF_SP)
         rd = {24'h000000, sp_r};
      else if (wb_adr_i == crj_pkg::OFF_FLAGS)
         rd = {24'h000000, flags_r};
      else if (wb_adr_i == crj_pkg::OFF_SYSMODE)
         rd = {24'h000000, sym_r};
      else if (wb_adr_i == crj_pkg::OFF_SHADOW)
         rd = {24'h000000, shadow_r};
      else if (wb_adr_i == crj_pkg::OFF_WRP)
         rd = {24'h000000, wrp_r};
      else if (wb_adr_i == crj_pkg::OFF_STATUS)
         rd = {29'h00000000, illegal_r, taken_r, busy_r};
      else if (wb_adr_i[9:8] == crj_pkg::WIN_REGFILE && wb_adr_i[7:IDXW+2] == '0)
         rd = {24'h000000, mem_r[wb_adr_i[IDXW+1:2]]};
      dat_nxt = ack_nxt ? rd : dat_r;

      // Writes only reach state while idle; unmapped writes are dropped
      if (commit && !busy_r)
      begin
         w = merge(rd, wb_dat_i, wb_sel_i);
         if (wb_adr_i == crj_pkg::OFF_CTRL)
         begin
            slow_nxt = w[crj_pkg::CTRL_SLOW];
            go = wb_sel_i[0] & wb_dat_i[crj_pkg::CTRL_GO];
            if (wb_sel_i[0] && wb_dat_i[crj_pkg::CTRL_FIRQ] && !go && sym_r[crj_pkg::SYM_GIE])
            begin
               pc_nxt = ip_r;
               ip_nxt = pc_r;
               shadow_nxt = flags_r;
               flags_nxt[crj_pkg::FL_FIS] = 1'b1;
               sym_nxt[crj_pkg::SYM_GIE] = 1'b0;
            end
         end
         else if (wb_adr_i == crj_pkg::OFF_INSTR)
            instr_nxt = w[23:0];
         else if (wb_adr_i == crj_pkg::OFF_PC)
            pc_nxt = w[15:0];
         else if (wb_adr_i == crj_pkg::OFF_IP)
            ip_nxt = w[15:0];
         else if (wb_adr_i == crj_pkg::OFF_SP)
            sp_nxt = w[7:0];
         else if (wb_adr_i == crj_pkg::OFF_FLAGS)
            flags_nxt = w[7:0];
         else if (wb_adr_i == crj_pkg::OFF_SYSMODE)
            sym_nxt = w[7:0];
         else if (wb_adr_i == crj_pkg::OFF_SHADOW)
            shadow_nxt = w[7:0];
         else if (wb_adr_i == crj_pkg::OFF_WRP)
            wrp_nxt = w[7:0];
         else if (wb_adr_i[9:8] == crj_pkg::WIN_REGFILE && wb_adr_i[7:IDXW+2] == '0)
         begin
            memWe = 1'b1;
            memIdx = wb_adr_i[IDXW+1:2];
            memData = w[7:0];
         end
      end

      if (go)
      begin
         busy_nxt = 1'b1;
         taken_nxt = 1'b0;
         illegal_nxt = 1'b0;
         cnt_nxt = cycFor(op, flags_r[crj_pkg::FL_FIS], slow_r) - 4'd1;
      end
      else if (busy_r && !retire)
         cnt_nxt = cnt_r - 4'd1;

      // Effects land together on the last cycle; flags untouched unless named
      if (retire)
      begin
         busy_nxt = 1'b0;
         fetch_nxt = 1'b1;
         if (op == crj_pkg::OP_INTERRUPT_RETURN_INSTR)
         begin
            sym_nxt[crj_pkg::SYM_GIE] = 1'b1;
            if (flags_r[crj_pkg::FL_FIS])
            begin
               pc_nxt = ip_r;
               ip_nxt = pc_r;
               flags_nxt = shadow_r;
               flags_nxt[crj_pkg::FL_FIS] = 1'b0;
            end
            else
            begin
               flags_nxt = rdReg(sp_r);
               pc_nxt = {rdReg(sp_r + 8'd1), rdReg(sp_r + 8'd2)};
               sp_nxt = sp_r + 8'd3;
            end
         end
         else if (op == crj_pkg::OP_JP_IND)
            pc_nxt = {rdReg(b1), rdReg(b1 + 8'd1)};
         else if (op[3:0] == crj_pkg::LO_JP)
         begin
            taken_nxt = condTrue;
            pc_nxt = condTrue ? {b1, b2} : pc_r + 16'd3;
         end
         else if (op[3:0] == crj_pkg::LO_JR)
         begin
            taken_nxt = condTrue;
            pc_nxt = pc_r + 16'd2 + (condTrue ? {{8{b1[7]}}, b1} : 16'h0000);
         end
         else
         begin
            pc_nxt = pc_r + ((cycFor(op, 1'b0, 1'b0) == crj_pkg::CYC_LONG) ? 16'd3 : 16'd2);
            wrEn = 1'b1;
            if (op[3:0] == crj_pkg::LO_LD_IM)
            begin
               wrAddr = workAddr(op[7:4]);
               wrData = b1;
            end
            else if (op[3:0] == crj_pkg::LO_LD_FROM)
            begin
               wrAddr = workAddr(op[7:4]);
               wrData = rdReg(b1);
            end
            else if (op[3:0] == crj_pkg::LO_LD_TO)
            begin
               wrAddr = b1;
               wrData = rdReg(workAddr(op[7:4]));
            end
            else if (op == crj_pkg::OP_LD_R_IR)
            begin
               wrAddr = workAddr(b1[7:4]);
               wrData = rdReg(rdReg(workAddr(b1[3:0])));
            end
            else if (op == crj_pkg::OP_LD_IR_R)
            begin
               wrAddr = rdReg(workAddr(b1[7:4]));
               wrData = rdReg(workAddr(b1[3:0]));
            end
            else if (op == crj_pkg::OP_LD_RR)
            begin
               wrAddr = b2;
               wrData = rdReg(b1);
            end
            else if (op == crj_pkg::OP_LD_R_IND)
            begin
               wrAddr = b2;
               wrData = rdReg(rdReg(b1));
            end
            else if (op == crj_pkg::OP_LD_R_IM)
            begin
               wrAddr = b1;
               wrData = b2;
            end
            else if (op == crj_pkg::OP_LD_IND_IM)
            begin
               wrAddr = rdReg(b1);
               wrData = b2;
            end
            else if (op == crj_pkg::OP_LD_IND_R)
            begin
               wrAddr = rdReg(b2);
               wrData = rdReg(b1);
            end
            else if (op == crj_pkg::OP_LDB)
            begin
               if (!b1[0])
               begin
                  wrAddr = workAddr(b1[7:4]);
                  old = rdReg(wrAddr);
                  src = rdReg(b2);
                  wrData = {old[7:1], src[b1[3:1]]};
               end
               else
               begin
                  wrAddr = b2;
                  old = rdReg(b2);
                  src = rdReg(workAddr(b1[7:4]));
                  wrData = old;
                  wrData[b1[3:1]] = src[0];
               end
            end
            else
            begin
               wrEn = 1'b0;
               illegal_nxt = 1'b1;
            end
         end
         if (wrEn)
         begin
            if (wrAddr == crj_pkg::FLAGS_ADDR)
               flags_nxt = wrData;
            else
            begin
               memWe = 1'b1;
               memIdx = wrAddr[IDXW-1:0];
               memData = wrData;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pc_r <= crj_pkg::RST_WORD;
         ip_r <= crj_pkg::RST_WORD;
         sp_r <= crj_pkg::RST_BYTE;
         flags_r <= crj_pkg::RST_BYTE;
         sym_r <= crj_pkg::RST_BYTE;
         shadow_r <= crj_pkg::RST_BYTE;
         wrp_r <= crj_pkg::RST_BYTE;
         instr_r <= 24'h000000;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
         slow_r <= 1'b0;
         taken_r <= 1'b0;
         illegal_r <= 1'b0;
         ack_r <= 1'b0;
         fetch_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         for (int i = 0; i < REG_DEPTH; i++)
            mem_r[i] <= crj_pkg::RST_BYTE;
      end
      else
      begin
         pc_r <= pc_nxt;
         ip_r <= ip_nxt;
         sp_r <= sp_nxt;
         flags_r <= flags_nxt;
         sym_r <= sym_nxt;
         shadow_r <= shadow_nxt;
         wrp_r <= wrp_nxt;
         instr_r <= instr_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         slow_r <= slow_nxt;
         taken_r <= taken_nxt;
         illegal_r <= illegal_nxt;
         ack_r <= ack_nxt;
         fetch_r <= fetch_nxt;
         dat_r <= dat_nxt;
         if (memWe)
            mem_r[memIdx] <= memData;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign busy = busy_r;
   assign globalIrqEnable = sym_r[crj_pkg::SYM_GIE];
   assign fetchNext = fetch_r;
endmodule

// ### tb/crj_exec_unit_checker.sv
// Port checks for the execution unit
`timescale 1ns/1ps
module crj_exec_checker
#(
   parameter int REG_DEPTH = 32
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic busy,
   input wire logic globalIrqEnable,
   input wire logic fetchNext
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_ack_taken: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_busy_cause: assert property ($rose(busy) |-> $past(wb_ack_o && wb_we_i))
      else $error("busy rose without a write");
   a_busy_min: assert property ($rose(busy) |-> busy[*4])
      else $error("instruction shorter than four cycles");
   a_busy_max: assert property ($rose(busy) |-> ##[4:12] !busy)
      else $error("instruction longer than twelve cycles");
   a_fetch_follow: assert property ($fell(busy) |-> ##[0:1] fetchNext)
      else $error("no fetch after retire");
   a_fetch_idle: assert property (fetchNext |-> !busy ##1 !fetchNext)
      else $error("fetch pulse while busy or too long");
   a_gie_set: assert property ($rose(globalIrqEnable) |-> ($fell(busy) || $past(wb_ack_o && wb_we_i)))
      else $error("interrupt enable rose without cause");
   a_gie_clear: assert property ($fell(globalIrqEnable) |-> $past(wb_ack_o && wb_we_i))
      else $error("interrupt enable fell without cause");

   c_retire: cover property ($fell(busy) ##1 fetchNext);
   c_gie_up: cover property ($rose(globalIrqEnable));
   c_gie_down: cover property ($fell(globalIrqEnable));
endmodule

bind crj_exec_unit crj_exec_checker #(.REG_DEPTH(REG_DEPTH)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .busy(busy),
   .globalIrqEnable(globalIrqEnable), .fetchNext(fetchNext));

// ### tb/crj_fetch_model.sv
// Fetch unit model counting fetch requests
`timescale 1ns/1ps
module crj_fetch_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic busy,
   input wire logic fetchNext,
   output logic [15:0] fetchCnt
);
   logic [15:0] fetchCnt_r;
   logic [15:0] fetchCnt_nxt;

   always_comb
   begin
      fetchCnt_nxt = fetchCnt_r;
      if (fetchNext && !busy)
         fetchCnt_nxt = fetchCnt_r + 16'h1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         fetchCnt_r <= 16'h0;
      else
         fetchCnt_r <= fetchCnt_nxt;
   end

   assign fetchCnt = fetchCnt_r;
endmodule

// ### tb/crj_exec_unit_tb.sv
// Testbench for the return, jump and load execution unit
`timescale 1ns/1ps
module crj_exec_unit_tb;
   logic clk_sys;
   logic rst;
   logic wbCyc;
   logic wbStb;
   logic wbWe;
   logic [9:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW;
   logic [31:0] wbDatR;
   logic wbAck;
   logic busy;
   logic gie;
   logic fetchNext;
   logic [15:0] fetchCnt;
   int errorCnt;
   int compares;
   int execCnt;

   crj_exec_unit #(.REG_DEPTH(32)) DUT (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .busy(busy), .globalIrqEnable(gie), .fetchNext(fetchNext));
   crj_fetch_model u_fetch (.clk_sys(clk_sys), .rst(rst), .busy(busy), .fetchNext(fetchNext),
      .fetchCnt(fetchCnt));

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errorCnt++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic wbx(input logic we, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      wbSel <= 4'hf;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wbAck !== 1'b1 && n < 20);
      chk("ack", 32'h1, {31'h0, wbAck});
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic wbw(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbx(1'b1, a, d, q);
   endtask

   task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      wbx(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask

   function automatic logic [9:0] ra(input int i);
      return 10'h100 + 10'(4 * i);
   endfunction

   // Loads opcode bytes, starts, counts busy cycles
   task automatic exec(input logic [23:0] ins, input logic [31:0] ctl, input int cyc);
      int n;
      wbw(crj_pkg::OFF_INSTR, {8'h00, ins});
      wbw(crj_pkg::OFF_CTRL, ctl);
      n = 0;
      @(posedge clk_sys);
      while (busy === 1'b1 && n < 40)
      begin
         n++;
         @(posedge clk_sys);
      end
      chk("cycles", 32'(cyc), 32'(n));
      chk("fetchNext", 32'h1, {31'h0, fetchNext});
      execCnt++;
   endtask

   task automatic t_reset;
      rc("pc", crj_pkg::OFF_PC, 32'h0);
      rc("flags", crj_pkg::OFF_FLAGS, 32'h0);
      rc("unmapped", 10'h0fc, 32'h0);
      chk("gie", 32'h0, {31'h0, gie});
   endtask

   task automatic t_jp;
      logic [3:0] cc [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
      for (int i = 0; i < 4; i++)
      begin
         wbw(crj_pkg::OFF_FLAGS, 32'h80);
         wbw(crj_pkg::OFF_PC, 32'h1000);
         exec({8'h34, 8'h12, cc[i], crj_pkg::LO_JP}, 32'h1, 8);
         rc("pc", crj_pkg::OFF_PC, (i == 1 || i == 2) ? 32'h1234 : 32'h1003);
         rc("status", crj_pkg::OFF_STATUS, (i == 1 || i == 2) ? 32'h2 : 32'h0);
         rc("flags", crj_pkg::OFF_FLAGS, 32'h80);
      end
      wbw(ra(4), 32'h01);
      wbw(ra(5), 32'h20);
      exec({8'h00, 8'h04, crj_pkg::OP_JP_IND}, 32'h1, 8);
      rc("pc", crj_pkg::OFF_PC, 32'h0120);
   endtask

   task automatic t_jr;
      logic [3:0] cc [3] = '{4'h8, 4'h8, 4'h0};
      logic [7:0] dsp [3] = '{8'h80, 8'h7f, 8'h7f};
      logic [31:0] ex [3] = '{32'h0f82, 32'h1081, 32'h1002};
      for (int i = 0; i < 3; i++)
      begin
         wbw(crj_pkg::OFF_PC, 32'h1000);
         exec({8'h00, dsp[i], cc[i], crj_pkg::LO_JR}, 32'h1, 6);
         rc("pc", crj_pkg::OFF_PC, ex[i]);
      end
   endtask

   task automatic t_ld;
      wbw(crj_pkg::OFF_WRP, 32'h0);
      wbw(crj_pkg::OFF_FLAGS, 32'h50);
      exec({8'h00, 8'h5a, 8'h3c}, 32'h1, 4);
      exec({8'h00, 8'h03, 8'h28}, 32'h1, 4);
      exec({8'h00, 8'h08, 8'h39}, 32'h1, 4);
      exec({8'ha5, 8'h07, crj_pkg::OP_LD_R_IM}, 32'h1, 6);
      rc("r2", ra(2), 32'h5a);
      rc("r3", ra(3), 32'h5a);
      rc("r8", ra(8), 32'h5a);
      rc("r7", ra(7), 32'ha5);
      wbw(ra(0), 32'h06);
      wbw(ra(1), 32'h05);
      exec({8'h01, 8'h04, crj_pkg::OP_LDB}, 32'h1, 6);
      rc("r0", ra(0), 32'h07);
      exec({8'h01, 8'h03, crj_pkg::OP_LDB}, 32'h1, 6);
      rc("reg1", ra(1), 32'h07);
      rc("flags", crj_pkg::OFF_FLAGS, 32'h50);
      exec({16'h0, 8'h87}, 32'h1, 4);
      rc("status", crj_pkg::OFF_STATUS, 32'h4);
   endtask

   task automatic t_interrupt_return_instr;
      for (int s = 0; s < 2; s++)
      begin
         wbw(crj_pkg::OFF_SP, 32'h10);
         wbw(ra(16), 32'hc0);
         wbw(ra(17), 32'h12);
         wbw(ra(18), 32'h34);
         wbw(crj_pkg::OFF_FLAGS, 32'h0);
         wbw(crj_pkg::OFF_SYSMODE, 32'h0);
         wbw(crj_pkg::OFF_CTRL, s ? 32'h4 : 32'h0);
         // no pending clear just before it
         exec({16'h0, crj_pkg::OP_INTERRUPT_RETURN_INSTR}, s ? 32'h5 : 32'h1, s ? 12 : 10);
         rc("ctrl", crj_pkg::OFF_CTRL, s ? 32'h4 : 32'h0);
         rc("pc", crj_pkg::OFF_PC, 32'h1234);
         rc("sp", crj_pkg::OFF_SP, 32'h13);
         rc("flags", crj_pkg::OFF_FLAGS, 32'hc0);
         chk("gie", 32'h1, {31'h0, gie});
      end
   endtask

   task automatic t_firq;
      wbw(crj_pkg::OFF_SYSMODE, 32'h0);
      wbw(crj_pkg::OFF_PC, 32'h0200);
      wbw(crj_pkg::OFF_IP, 32'h0100);
      wbw(crj_pkg::OFF_FLAGS, 32'h40);
      wbw(crj_pkg::OFF_CTRL, 32'h2);
      rc("pc", crj_pkg::OFF_PC, 32'h0200);
      wbw(crj_pkg::OFF_SYSMODE, 32'h1);
      wbw(crj_pkg::OFF_CTRL, 32'h2);
      rc("pc", crj_pkg::OFF_PC, 32'h0100);
      rc("ip", crj_pkg::OFF_IP, 32'h0200);
      rc("flags", crj_pkg::OFF_FLAGS, 32'h42);
      chk("gie", 32'h0, {31'h0, gie});
      exec({16'h0, crj_pkg::OP_INTERRUPT_RETURN_INSTR}, 32'h1, 6);
      rc("pc", crj_pkg::OFF_PC, 32'h0200);
      rc("ip", crj_pkg::OFF_IP, 32'h0100);
      rc("flags", crj_pkg::OFF_FLAGS, 32'h40);
      chk("gie", 32'h1, {31'h0, gie});
   endtask

   task automatic printVerdict;
      if (errorCnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errorCnt++;
      printVerdict;
   end

   initial
   begin
      rst = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 10'h000;
      wbSel = 4'h0;
      wbDatW = 32'h0;
      errorCnt = 0;
      compares = 0;
      execCnt = 0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_jp;
      t_jr;
      t_ld;
      t_interrupt_return_instr;
      t_firq;
      chk("fetches", 32'(execCnt), {16'h0, fetchCnt});
      printVerdict;
   end
endmodule
